// ==== rtl/spm_ctrl.sv ====
// power mode controller with Avalon-MM register slave
//
// Overview of operation
// RQ1: after reset the mode field reads 00, normal operation.
// RQ2: normal mode keeps PLL clocks, PHY, MAC and host interface all on.
// RQ3: from normal mode, a host write selects any other mode.
// RQ4: power saving only when field is 11, autoneg on, cable unplugged.
// RQ5: power saving keeps PLL, MAC, host on, PHY tx on, unused rx off.
// RQ6: line activity in power saving restores PHY receiver to full power.
// RQ7: from power saving, a host write selects any other mode.
// RQ8: field 01 enters energy detect, with awake and sleep sub-states.
// RQ9: no energy beyond idle-to-sleep time moves awake to sleep.
// RQ10: sleep disables all but the receiver energy detector.
// RQ11: energy seen while asleep returns to the awake sub-state.
// RQ12: energy detect without link emits 120 ns pulses once per second.
// RQ13: mode register bit 2 set disables the PLL in energy detect.
// RQ14: field 10 stops PLL clocks, turns off PHY and MAC, keeps registers.
// RQ15: writing 00 leaves soft power down back to normal operation.
// RQ16: bit 3 of each port control register powers down that PHY.
// RQ17: per-port power down acts independently of the global mode field.
// RQ18: a mode write starts its transition on the next clock cycle.
// RQ19: a mode written mid-transition is kept and applied afterwards.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
`include "spm_map.svh"
module spm_ctrl
  import spm_pkg::*;
#(
  parameter int unsigned PULSE_PERIOD_CYC = `SPM_PULSE_PERIOD_CYC,
  parameter int unsigned SLEEP_UNIT_CYC   = `SPM_SLEEP_UNIT_CYC
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // line status
  input  wire logic        autoneg_en_i,
  input  wire logic        cable_connected_i,
  input  wire logic        link_up_i,
  input  wire logic        energy_det_i,
  // power controls
  output logic             pll_en_o,
  output logic             mac_en_o,
  output logic             host_if_en_o,
  output logic             phy_tx_en_o,
  output logic             phy_rx_en_o,
  output logic             energy_det_en_o,
  output logic [1:0]       port_pd_o,
  output logic             link_pulse_o
);

  // refuse a pulse period no longer than the pulse, or an empty sleep unit
  if (PULSE_PERIOD_CYC <= `SPM_PULSE_CYC || SLEEP_UNIT_CYC < 1) begin : g_bad_timing
    $error("spm_ctrl: unsupported timing parameters");
  end

  typedef struct packed {
    spm_state_e  st;
    spm_mode_t   applied;
    logic [7:0]  mode_reg;
    logic [7:0]  idle_reg;
    logic [7:0]  p1_reg;
    logic [7:0]  p2_reg;
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] unit_cnt;
    logic [8:0]  idle_cnt;
    logic [31:0] pulse_cnt;
    logic        pll;
    logic        mac;
    logic        host;
    logic        tx;
    logic        rx;
    logic        edet;
    logic [1:0]  pd;
    logic        pulse;
  } spm_regs_s;

  spm_regs_s q, d;
  logic      access;
  logic      wr_hit;
  spm_mode_t req_mode;

  assign access            = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = access & ~q.ack;
  assign avs_readdata_o    = q.rdata;
  assign pll_en_o          = q.pll;
  assign mac_en_o          = q.mac;
  assign host_if_en_o      = q.host;
  assign phy_tx_en_o       = q.tx;
  assign phy_rx_en_o       = q.rx;
  assign energy_det_en_o   = q.edet;
  assign port_pd_o         = q.pd;
  assign link_pulse_o      = q.pulse;
  // a write with byte lane 0 enabled lands at the edge where waitrequest is low
  assign wr_hit            = avs_write_i & q.ack & avs_byteenable_i[0];
  assign req_mode          = q.mode_reg[1:0];

  always_comb begin
    d       = q;
    d.ack   = access & ~q.ack;
    // register slave: one wait cycle, then answer
    if (avs_read_i & ~q.ack) begin
      d.rdata = 32'h0000_0000;
      case (avs_address_i)
        `SPM_OFS_PORT1_CTRL: d.rdata[7:0] = q.p1_reg;
        `SPM_OFS_PORT2_CTRL: d.rdata[7:0] = q.p2_reg;
        `SPM_OFS_MODE_CTRL:  d.rdata[7:0] = q.mode_reg;
        `SPM_OFS_IDLE_SLEEP: d.rdata[7:0] = q.idle_reg;
        `SPM_OFS_STATUS:     d.rdata[7:0] = {3'h0, 2'(q.st == SPM_ED_SLEEP), q.pll, q.applied};
        default:             d.rdata = 32'h0000_0000;
      endcase
    end
    // register contents are held in every mode [RQ14]
    if (wr_hit) begin
      case (avs_address_i)
        `SPM_OFS_PORT1_CTRL: d.p1_reg   = avs_writedata_i[7:0];
        `SPM_OFS_PORT2_CTRL: d.p2_reg   = avs_writedata_i[7:0];
        `SPM_OFS_MODE_CTRL:  d.mode_reg = avs_writedata_i[7:0];
        `SPM_OFS_IDLE_SLEEP: d.idle_reg = avs_writedata_i[7:0];
        default:             d.rdata    = q.rdata;
      endcase
    end
    // mode state machine
    case (q.st)
      SPM_NORMAL: begin
        if (req_mode != SPM_MODE_NORMAL) begin
          d.st = SPM_SWITCH;                                  // [RQ3] [RQ18]
        end
      end
      SPM_SAVING: begin
        if (req_mode != SPM_MODE_SAVING || !autoneg_en_i) begin
          d.st = SPM_SWITCH;                                  // [RQ7] [RQ18]
        end
      end
      SPM_ED_AWAKE, SPM_ED_SLEEP: begin
        if (req_mode != SPM_MODE_ENERGY) begin
          d.st = SPM_SWITCH;                                  // [RQ18]
        end else if (energy_det_i) begin
          d.st       = SPM_ED_AWAKE;                          // [RQ11]
          d.idle_cnt = 9'h000;
          d.unit_cnt = 32'h0000_0000;
        end else if (q.st == SPM_ED_AWAKE) begin
          if (q.unit_cnt >= SLEEP_UNIT_CYC - 1) begin
            d.unit_cnt = 32'h0000_0000;
            d.idle_cnt = q.idle_cnt + 9'h001;
          end else begin
            d.unit_cnt = q.unit_cnt + 32'h0000_0001;
          end
          if (q.idle_cnt > {1'b0, q.idle_reg}) begin
            d.st = SPM_ED_SLEEP;                              // [RQ9]
          end
        end
      end
      SPM_SOFT_PD: begin
        if (req_mode == SPM_MODE_NORMAL) begin
          d.st = SPM_SWITCH;                                  // [RQ15]
        end
      end
      SPM_SWITCH: begin
        // latest written field is applied here [RQ19]
        d.applied  = req_mode;
        d.idle_cnt = 9'h000;
        d.unit_cnt = 32'h0000_0000;
        case (req_mode)
          SPM_MODE_ENERGY: d.st = SPM_ED_AWAKE;               // [RQ8]
          SPM_MODE_SOFTPD: d.st = SPM_SOFT_PD;                // [RQ14]
          SPM_MODE_SAVING: d.st = autoneg_en_i ? SPM_SAVING : SPM_NORMAL; // [RQ4]
          default:         d.st = SPM_NORMAL;
        endcase
      end
      default: d.st = SPM_NORMAL;
    endcase
    // block enables per state
    d.pll  = 1'b1;
    d.mac  = 1'b1;
    d.host = 1'b1;
    d.tx   = 1'b1;
    d.rx   = 1'b1;
    d.edet = 1'b0;
    case (d.st)
      SPM_SAVING: begin
        d.rx = cable_connected_i;                             // [RQ4] [RQ5] [RQ6]
      end
      SPM_ED_AWAKE: begin
        d.pll  = ~q.mode_reg[`SPM_BIT_PLL_OFF];               // [RQ13]
        d.edet = 1'b1;
      end
      SPM_ED_SLEEP: begin
        d.pll  = 1'b0;                                        // [RQ10]
        d.mac  = 1'b0;                                        // [RQ10]
        d.host = 1'b0;
        d.tx   = 1'b0;
        d.rx   = 1'b0;
        d.edet = 1'b1;
      end
      SPM_SOFT_PD: begin
        d.pll  = 1'b0;                                        // [RQ14]
        d.mac  = 1'b0;
        d.host = 1'b0;
        d.tx   = 1'b0;
        d.rx   = 1'b0;
      end
      default: d.edet = 1'b0;                                 // [RQ2]
    endcase
    // link pulses while in energy detect without a link
    d.pulse = 1'b0;
    if ((q.st == SPM_ED_AWAKE || q.st == SPM_ED_SLEEP) && !link_up_i) begin
      if (q.pulse_cnt >= PULSE_PERIOD_CYC - 1) begin
        d.pulse_cnt = 32'h0000_0000;
      end else begin
        d.pulse_cnt = q.pulse_cnt + 32'h0000_0001;
      end
      d.pulse = (q.pulse_cnt < 32'(`SPM_PULSE_CYC));          // [RQ12]
    end else begin
      d.pulse_cnt = 32'h0000_0000;
    end
    // per-port power down, regardless of mode
    d.pd = {q.p2_reg[`SPM_BIT_PORT_PD], q.p1_reg[`SPM_BIT_PORT_PD]}; // [RQ16] [RQ17]
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q           <= '0;
      q.st        <= SPM_NORMAL;
      q.applied   <= SPM_MODE_NORMAL;
      q.mode_reg  <= `SPM_RST_MODE_CTRL;                      // [RQ1]
      q.idle_reg  <= `SPM_RST_IDLE_SLEEP;
      q.p1_reg    <= `SPM_RST_PORT_CTRL;
      q.p2_reg    <= `SPM_RST_PORT_CTRL;
      q.pll       <= 1'b1;
      q.mac       <= 1'b1;
      q.host      <= 1'b1;
      q.tx        <= 1'b1;
      q.rx        <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : spm_ctrl

// ==== rtl/spm_map.svh ====
// register offsets, field positions, reset values and timing counts for the power mode controller
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH
`define SPM_OFS_PORT1_CTRL    8'h1D
`define SPM_OFS_PORT2_CTRL    8'h2D
`define SPM_OFS_MODE_CTRL     8'hC3
`define SPM_OFS_IDLE_SLEEP    8'hC4
`define SPM_OFS_STATUS        8'hC5
`define SPM_BIT_PORT_PD       3
`define SPM_BIT_PLL_OFF       2
`define SPM_RST_MODE_CTRL     8'h00
`define SPM_RST_IDLE_SLEEP    8'hFF
`define SPM_RST_PORT_CTRL     8'h00
`define SPM_CLK_MHZ           250
`define SPM_PULSE_NS          120
`define SPM_PULSE_CYC         ((`SPM_PULSE_NS * `SPM_CLK_MHZ + 999) / 1000)
`define SPM_PULSE_PERIOD_MS   1000
`define SPM_PULSE_PERIOD_CYC  (`SPM_PULSE_PERIOD_MS * `SPM_CLK_MHZ * 1000)
`define SPM_SLEEP_UNIT_MS     1
`define SPM_SLEEP_UNIT_CYC    (`SPM_SLEEP_UNIT_MS * `SPM_CLK_MHZ * 1000)
`endif

// ==== rtl/spm_pkg.sv ====
// types for the power mode controller
package spm_pkg;
  typedef enum logic [2:0] {
    SPM_NORMAL,
    SPM_SAVING,
    SPM_ED_AWAKE,
    SPM_ED_SLEEP,
    SPM_SOFT_PD,
    SPM_SWITCH
  } spm_state_e;
  typedef logic [1:0] spm_mode_t;
  localparam spm_mode_t SPM_MODE_NORMAL = 2'h0;
  localparam spm_mode_t SPM_MODE_ENERGY = 2'h1;
  localparam spm_mode_t SPM_MODE_SOFTPD = 2'h2;
  localparam spm_mode_t SPM_MODE_SAVING = 2'h3;
endpackage : spm_pkg

// ==== sim/spm_ctrl_properties.sv ====
// port assertions for the power mode controller
`timescale 1ns/1ns
module spm_properties (
  // clock, reset and bus
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  // line and power
  input wire logic        energy_det_i,
  input wire logic        pll_en_o,
  input wire logic        mac_en_o,
  input wire logic        host_if_en_o,
  input wire logic        phy_tx_en_o,
  input wire logic        phy_rx_en_o,
  input wire logic        energy_det_en_o,
  input wire logic [1:0]  port_pd_o,
  input wire logic        link_pulse_o
);
  logic [5:0] hi_q;
  logic       wack;
  assign wack = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // counts cycles of the link pulse
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i) hi_q <= 6'h00;
    else hi_q <= link_pulse_o ? hi_q + 6'h01 : 6'h00;
  a_one_wait: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  a_req_waits: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read answered early");
  a_mac_host: assert property (mac_en_o == host_if_en_o)
    else $error("mac and host differ");
  a_rx_tx: assert property (phy_rx_en_o |-> phy_tx_en_o)
    else $error("receiver on without transmitter");
  a_sleep_dark: assert property (
    energy_det_en_o && !mac_en_o |-> !pll_en_o && !phy_tx_en_o && !phy_rx_en_o)
    else $error("sleep leaves circuits on");
  a_wake_fast: assert property (
    energy_det_en_o && !mac_en_o && energy_det_i |-> ##[1:4] mac_en_o)
    else $error("no wake on energy");
  a_softpd_quick: assert property (
    wack && avs_address_i == 8'hC3 && avs_writedata_i[1:0] == 2'h2
    |-> ##[1:4] (!pll_en_o && !mac_en_o && !phy_tx_en_o))
    else $error("soft power down late");
  a_pd_by_write: assert property (
    $changed(port_pd_o) |-> $past(wack) || $past(wack, 2))
    else $error("port power down moved alone");
  a_pulse_len: assert property (
    $fell(link_pulse_o) && $past(energy_det_en_o) |-> hi_q == 6'h1E)
    else $error("link pulse width wrong");
endmodule : spm_properties
bind spm_ctrl spm_properties u_props (.*);

// ==== sim/switch_power_mode_controller_tb.sv ====
// self-checking bench for the power mode controller
`timescale 1ns/1ns
module switch_power_mode_controller_tb;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic        autoneg_en_i = 1'b1, cable_connected_i = 1'b0, link_up_i = 1'b0;
  logic        energy_det_i = 1'b1, avs_waitrequest_o, pll_en_o, mac_en_o, host_if_en_o;
  logic        phy_tx_en_o, phy_rx_en_o, energy_det_en_o, link_pulse_o, lp;
  logic [1:0]  port_pd_o;
  int          miscompares = 0, tests_run = 0, n;
  wire  [5:0]  pwr = {pll_en_o, mac_en_o, host_if_en_o, phy_tx_en_o, phy_rx_en_o, energy_det_en_o};
  spm_ctrl #(.PULSE_PERIOD_CYC(100), .SLEEP_UNIT_CYC(4)) dut (.*);
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d, logic [3:0] be);
    int k;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 50) begin
      miscompares++;
      summarize();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : acc
  task automatic rd(logic [7:0] a, logic [7:0] e);
    acc(1'b0, a, 8'h00, 4'hF);
    chk($sformatf("reg %h", a), q, {24'h0, e});
  endtask : rd
  task automatic md(logic [7:0] d, logic [5:0] m, logic [5:0] e);
    acc(1'b1, 8'hC3, d, 4'hF);
    repeat (3) @(posedge clk_sys_i);
    chk("power", pwr & m, e);
  endtask : md
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(8'hC3, 8'h00);
    rd(8'hC4, 8'hFF);
    rd(8'h10, 8'h00);
    chk("power", pwr, 6'h3E);
    $display("test reset done");
    md(8'h03, 6'h3F, 6'h3C);
    cable_connected_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("power", pwr, 6'h3E);
    md(8'h02, 6'h3F, 6'h00);
    rd(8'hC4, 8'hFF);
    md(8'h01, 6'h3F, 6'h00);
    md(8'h00, 6'h3F, 6'h3E);
    acc(1'b1, 8'hC3, 8'h02, 4'hF);
    md(8'h00, 6'h3F, 6'h3E);
    $display("test modes done");
    acc(1'b1, 8'hC4, 8'h02, 4'hF);
    energy_det_i <= 1'b0;
    md(8'h01, 6'h3E, 6'h3E);
    for (n = 0; n < 200 && mac_en_o !== 1'b0; n++) @(posedge clk_sys_i);
    chk("sleep delay", n > 4 && n < 20, 1);
    chk("power", pwr, 6'h01);
    n = 0;
    lp = 1'b0;
    repeat (250) begin
      @(posedge clk_sys_i);
      if (link_pulse_o === 1'b1 && !lp) n++;
      lp = link_pulse_o;
    end
    chk("pulses", n inside {[2:3]}, 1);
    energy_det_i <= 1'b1;
    for (n = 0; n < 10 && mac_en_o !== 1'b1; n++) @(posedge clk_sys_i);
    chk("wake", mac_en_o, 1);
    md(8'h05, 6'h30, 6'h10);
    md(8'h00, 6'h3F, 6'h3E);
    rd(8'hC5, 8'h04);
    $display("test energy done");
    acc(1'b1, 8'h1D, 8'h08, 4'hF);
    acc(1'b1, 8'h2D, 8'h08, 4'hF);
    repeat (2) @(posedge clk_sys_i);
    chk("ports", port_pd_o, 2'h3);
    acc(1'b1, 8'h2D, 8'h00, 4'h0);
    acc(1'b1, 8'h1D, 8'h00, 4'hF);
    rd(8'h2D, 8'h08);
    chk("ports", port_pd_o, 2'h2);
    $display("test ports done");
    summarize();
  end
endmodule : switch_power_mode_controller_tb
